// ### design/irq_flags_pkg.sv
// constants for the peripheral interrupt flag bank
// assumes a 32-bit axi4-lite register bus, byte addresses = 4 * index
package irq_flags_pkg;

    // ************************************************
    // register indices (byte address = 4 * index)
    // ************************************************
    localparam logic [7:0] IDX_FLAGS_1   = 8'h0c;
    localparam logic [7:0] IDX_FLAGS_2   = 8'h0d;
    localparam logic [7:0] IDX_ENABLES_1 = 8'h8c;
    localparam logic [7:0] IDX_ENABLES_2 = 8'h8d;
    localparam logic [7:0] IDX_CONTROL   = 8'h90;

    localparam int ADDR_W = 12;

    // ************************************************
    // field positions
    // ************************************************
    localparam int BIT_PSP   = 7;
    localparam int BIT_ADC   = 6;
    localparam int BIT_RXF   = 5;
    localparam int BIT_TXE   = 4;
    localparam int BIT_SSP   = 3;
    localparam int BIT_CCP1  = 2;
    localparam int BIT_TIMER2_COUNT  = 1;
    localparam int BIT_TMR1  = 0;
    localparam int BIT_CAPCOMP2_MODULE  = 0;
    localparam int BIT_GIE   = 0;
    localparam int BIT_PSPEN = 1;

    // ************************************************
    // reset values and masks
    // ************************************************
    localparam logic [7:0] FLAGS_RESET    = 8'h00;
    localparam logic [7:0] ENABLES_RESET  = 8'h00;
    localparam logic [7:0] CONTROL_RESET  = 8'h02;
    localparam logic [7:0] FLAGS1_RW_MASK = 8'hcf;
    localparam logic [7:0] FLAGS2_RW_MASK = 8'h01;
    localparam logic [7:0] ENABLES2_MASK  = 8'h01;
    localparam logic [7:0] CONTROL_MASK   = 8'h03;

    // ************************************************
    // bus responses
    // ************************************************
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : irq_flags_pkg

// ### design/sticky_flags.sv
// a bank of sticky flags: hardware set, software write, hardware clear
// assumes all inputs synchronous to clk; set always beats any clear
`timescale 1ns/1ns
`default_nettype none
module sticky_flags #(
    parameter int         W     = 8,
    parameter logic [7:0] RESET = 8'h00
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    // hardware events
    input  wire logic [W-1:0] set_bits,
    input  wire logic [W-1:0] clr_bits,
    // software write
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_mask,
    input  wire logic [W-1:0] wr_data,
    // flag state
    output var  logic [W-1:0] flags
);

    wire [W-1:0] wr_ones  = wr_en ? (wr_mask & wr_data) : '0;
    wire [W-1:0] wr_zeros = wr_en ? (wr_mask & ~wr_data) : '0;
    // set wins over software and hardware clears
    wire [W-1:0] next_flags = set_bits | wr_ones | (flags & ~clr_bits & ~wr_zeros);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= RESET[W-1:0];
        end else begin
            flags <= next_flags;
        end
    end

endmodule : sticky_flags
`default_nettype wire

// ### design/peripheral_irq_flags.sv
// peripheral interrupt flags and enables behind an axi4-lite slave
// assumes event inputs are one-cycle pulses synchronous to core_clk
`timescale 1ns/1ns
`default_nettype none
module peripheral_irq_flags (
    // clock and reset
    input  wire logic                               core_clk,
    input  wire logic                               rst_n,
    // peripheral events
    input  wire logic                               psp_access_evt,
    input  wire logic                               conversion_done_evt,
    input  wire logic                               rx_full_evt,
    input  wire logic                               rx_buffer_read,
    input  wire logic                               tx_empty_evt,
    input  wire logic                               tx_buffer_write,
    input  wire logic                               sync_serial_evt,
    input  wire logic                               capcomp1_evt,
    input  wire logic [7:0]                         timer2_count,
    input  wire logic [7:0]                         timer2_period,
    input  wire logic                               timer1_overflow_evt,
    input  wire logic                               capcomp2_evt,
    // interrupt
    output var  logic                               irq,
    // axi4-lite write address and data
    input  wire logic [irq_flags_pkg::ADDR_W-1:0]   awaddr,
    input  wire logic                               awvalid,
    output var  logic                               awready,
    input  wire logic [31:0]                        wdata,
    input  wire logic [3:0]                         wstrb,
    input  wire logic                               wvalid,
    output var  logic                               wready,
    // axi4-lite write response
    output var  logic [1:0]                         bresp,
    output var  logic                               bvalid,
    input  wire logic                               bready,
    // axi4-lite read
    input  wire logic [irq_flags_pkg::ADDR_W-1:0]   araddr,
    input  wire logic                               arvalid,
    output var  logic                               arready,
    output var  logic [31:0]                        rdata,
    output var  logic [1:0]                         rresp,
    output var  logic                               rvalid,
    input  wire logic                               rready
);
    import irq_flags_pkg::*;

    // ************************************************
    // helpers
    // ************************************************
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        hit = (addr[ADDR_W-1:2] == {2'h0, idx});
    endfunction : hit

    function automatic logic mapped(input logic [ADDR_W-1:0] addr);
        mapped = hit(addr, IDX_FLAGS_1) | hit(addr, IDX_FLAGS_2) | hit(addr, IDX_ENABLES_1)
               | hit(addr, IDX_ENABLES_2) | hit(addr, IDX_CONTROL);
    endfunction : mapped

    // ************************************************
    // write channel
    // ************************************************
    logic [ADDR_W-1:0] aw_addr;
    logic              aw_held;
    logic [7:0]        w_byte;
    logic              w_lane0;
    logic              w_held;

    wire aw_take = awvalid & awready;
    wire w_take  = wvalid & wready;
    // write performed once both halves are held and no response pends
    wire wr_go   = aw_held & w_held & ~bvalid;
    wire wr_lane = wr_go & w_lane0;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_addr <= '0;
            aw_held <= 1'b0;
            awready <= 1'b1;
        end else if (aw_take) begin
            aw_addr <= awaddr;
            aw_held <= 1'b1;
            awready <= 1'b0;
        end else if (bvalid & bready) begin
            aw_held <= 1'b0;
            awready <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_byte  <= 8'h00;
            w_lane0 <= 1'b0;
            w_held  <= 1'b0;
            wready  <= 1'b1;
        end else if (w_take) begin
            w_byte  <= wdata[7:0];
            w_lane0 <= wstrb[0];
            w_held  <= 1'b1;
            wready  <= 1'b0;
        end else if (bvalid & bready) begin
            w_held  <= 1'b0;
            wready  <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp  <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    wire wr_flags_1   = wr_lane & hit(aw_addr, IDX_FLAGS_1);
    wire wr_flags_2   = wr_lane & hit(aw_addr, IDX_FLAGS_2);
    wire wr_enables_1 = wr_lane & hit(aw_addr, IDX_ENABLES_1);
    wire wr_enables_2 = wr_lane & hit(aw_addr, IDX_ENABLES_2);
    wire wr_control   = wr_lane & hit(aw_addr, IDX_CONTROL);

    // ************************************************
    // enables and control
    // ************************************************
    logic [7:0] peripheral_enables_1;
    logic [7:0] peripheral_enables_2;
    logic [7:0] interrupt_control_reg;

    wire global_irq_enable = interrupt_control_reg[BIT_GIE];
    wire psp_present       = interrupt_control_reg[BIT_PSPEN];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            peripheral_enables_1 <= ENABLES_RESET;
        end else if (wr_enables_1) begin
            peripheral_enables_1 <= w_byte;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            peripheral_enables_2 <= ENABLES_RESET;
        end else if (wr_enables_2) begin
            peripheral_enables_2 <= w_byte & ENABLES2_MASK;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_control_reg <= CONTROL_RESET;
        end else if (wr_control) begin
            interrupt_control_reg <= w_byte & CONTROL_MASK;
        end
    end

    // ************************************************
    // timer2 match detect
    // ************************************************
    // edge of equality, so a long stall on the match value sets only once
    logic t2_equal_q;
    wire  t2_equal = (timer2_count == timer2_period);
    wire  t2_match = t2_equal & ~t2_equal_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            t2_equal_q <= 1'b0;
        end else begin
            t2_equal_q <= t2_equal;
        end
    end

    // ************************************************
    // flag banks
    // ************************************************
    logic [7:0] peripheral_flags_1;
    logic [0:0] flags_2_bit;

    // event order, bit 7 to 0
    wire [7:0] set_1 = {psp_access_evt & psp_present, conversion_done_evt, rx_full_evt,
                        tx_empty_evt, sync_serial_evt, capcomp1_evt, t2_match,
                        timer1_overflow_evt};
    wire [7:0] clr_1 = {~psp_present, 2'h0, 1'b0, 4'h0}
                     | {2'h0, rx_buffer_read, tx_buffer_write, 4'h0};
    // receive and transmit flags not writable
    wire [7:0] mask_1 = FLAGS1_RW_MASK & {psp_present, 7'h7f};

    sticky_flags #(
        .W     (8),
        .RESET (FLAGS_RESET)
    ) u_flags_1 (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .set_bits (set_1),
        .clr_bits (clr_1),
        .wr_en    (wr_flags_1),
        .wr_mask  (mask_1),
        .wr_data  (w_byte),
        .flags    (peripheral_flags_1)
    );

    sticky_flags #(
        .W     (1),
        .RESET (FLAGS_RESET)
    ) u_flags_2 (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .set_bits (capcomp2_evt),
        .clr_bits (1'b0),
        .wr_en    (wr_flags_2),
        .wr_mask  (FLAGS2_RW_MASK[BIT_CAPCOMP2_MODULE]),
        .wr_data  (w_byte[BIT_CAPCOMP2_MODULE]),
        .flags    (flags_2_bit)
    );

    wire [7:0] peripheral_flags_2 = {7'h00, flags_2_bit};

    // ************************************************
    // interrupt output
    // ************************************************
    // enables gate delivery only; flags latch whatever the enables say
    wire pending = |(peripheral_flags_1 & peripheral_enables_1)
                 | |(peripheral_flags_2 & peripheral_enables_2);
    wire next_irq = pending & global_irq_enable;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    // ************************************************
    // read channel
    // ************************************************
    wire ar_take = arvalid & arready;
    wire [7:0] rd_byte =
        hit(araddr, IDX_FLAGS_1)   ? peripheral_flags_1   :
        hit(araddr, IDX_FLAGS_2)   ? peripheral_flags_2   :
        hit(araddr, IDX_ENABLES_1) ? peripheral_enables_1 :
        hit(araddr, IDX_ENABLES_2) ? peripheral_enables_2 :
        hit(araddr, IDX_CONTROL)   ? interrupt_control_reg : 8'h00;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0;
            rresp   <= RESP_OKAY;
        end else if (ar_take) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h0, rd_byte};
            rresp   <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid & rready) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    chk_event_sets_adc: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        conversion_done_evt |=> peripheral_flags_1[BIT_ADC])
        else $error("conversion done event did not set its flag");

    chk_enable2_write: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wr_enables_2 |=> peripheral_enables_2 == ($past(w_byte) & ENABLES2_MASK))
        else $error("second enable register did not take the write");

    chk_capcomp2_module_flag_set: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        capcomp2_evt ##1 (!wr_flags_2 && !capcomp2_evt)[*2] |-> peripheral_flags_2[BIT_CAPCOMP2_MODULE])
        else $error("capcomp2 flag not held after its event");

    chk_flags1_readback: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (ar_take && hit(araddr, IDX_FLAGS_1)) |=> rvalid && rdata[7:0] == $past(peripheral_flags_1))
        else $error("first flag register read back wrong");

    chk_reserved_bit7: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !psp_present |=> !peripheral_flags_1[BIT_PSP])
        else $error("reserved bit 7 set without parallel port");

    chk_readonly_rx: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (wr_flags_1 && !rx_full_evt && !rx_buffer_read)
        |=> peripheral_flags_1[BIT_RXF] == $past(peripheral_flags_1[BIT_RXF]))
        else $error("software write changed read-only receive flag");

    chk_t2_match_sets: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (t2_equal && !t2_equal_q) |=> peripheral_flags_1[BIT_TIMER2_COUNT])
        else $error("timer2 match did not set flag");

    chk_t2_flag_holds: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (peripheral_flags_1[BIT_TIMER2_COUNT] && !wr_flags_1) |=> peripheral_flags_1[BIT_TIMER2_COUNT])
        else $error("timer2 flag dropped without software clear");

    chk_rx_read_clears: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (rx_buffer_read && !rx_full_evt) |=> !peripheral_flags_1[BIT_RXF])
        else $error("receive buffer read did not clear flag");

    chk_tx_write_clears: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (tx_buffer_write && !tx_empty_evt) |=> !peripheral_flags_1[BIT_TXE])
        else $error("transmit buffer write did not clear flag");

    chk_readonly_tx: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (wr_flags_1 && !tx_empty_evt && !tx_buffer_write)
        |=> peripheral_flags_1[BIT_TXE] == $past(peripheral_flags_1[BIT_TXE]))
        else $error("software write changed read-only transmit flag");

    chk_sw_zero_clears: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (wr_flags_1 && !w_byte[BIT_ADC] && !conversion_done_evt) |=> !peripheral_flags_1[BIT_ADC])
        else $error("software zero write did not clear conversion flag");

    chk_irq_follows: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (pending && global_irq_enable) |=> irq)
        else $error("interrupt not raised for pending enabled flag");

endmodule : peripheral_irq_flags
`default_nettype wire

// ### tb/periph_model.sv
// peripheral units model: event pulses and a timer2 counter
// assumes one-cycle requests from the bench, all on core_clk
`timescale 1ns/1ns
`default_nettype none
module periph_model (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // bench control
    input  wire logic [10:0] req,
    input  wire logic        t2_run,
    input  wire logic [7:0]  t2_period,
    // toward the flag bank
    output var  logic [10:0] evt,
    output var  logic [7:0]  t2_count
);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) evt <= 11'h000;
        else evt <= req;
    end

    // count restarts after period match
    // match lasts one cycle, so a halted timer never parks on it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) t2_count <= 8'h00;
        else if (t2_count == t2_period) t2_count <= 8'h00;
        else if (t2_run) t2_count <= t2_count + 8'h01;
    end
endmodule : periph_model
`default_nettype wire

// ### tb/peripheral_irq_flags_tb.sv
// self-checking bench for the peripheral flag bank
// assumes registered axi4-lite slave outputs and a 25 MHz core_clk
`timescale 1ns/1ns
`default_nettype none
module peripheral_irq_flags_tb;
    import irq_flags_pkg::*;
    logic        core_clk, rst_n, t2_run, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [10:0] req, evt;
    logic [7:0]  t2_period, t2_count;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    int          n_fail, tests_run, i, m_f1, m_f2, m_en2;
    logic [7:0]  d;

    // ************************************************
    // clock, partner and design
    // ************************************************
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    periph_model peri_u (.core_clk(core_clk), .rst_n(rst_n), .req(req), .t2_run(t2_run),
        .t2_period(t2_period), .evt(evt), .t2_count(t2_count));
    peripheral_irq_flags dut_u (.core_clk(core_clk), .rst_n(rst_n), .psp_access_evt(evt[7]),
        .conversion_done_evt(evt[6]), .rx_full_evt(evt[5]), .rx_buffer_read(evt[9]),
        .tx_empty_evt(evt[4]), .tx_buffer_write(evt[10]), .sync_serial_evt(evt[3]),
        .capcomp1_evt(evt[2]), .timer2_count(t2_count), .timer2_period(t2_period),
        .timer1_overflow_evt(evt[0]), .capcomp2_evt(evt[8]), .irq(irq), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready));

    // ************************************************
    // bus cycles and checks
    // ************************************************
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (e !== g) begin
            n_fail++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        @(posedge core_clk);
        awaddr  <= {2'b00, idx, 2'b00};
        wdata   <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rdr(input logic [7:0] idx);
        @(posedge core_clk);
        araddr  <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rdr

    task automatic pulse(input int b);
        @(posedge core_clk);
        req <= 11'(1 << b);
        @(posedge core_clk);
        req <= 11'h000;
        repeat (3) @(posedge core_clk);
    endtask : pulse

    task automatic stop_test;
        if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test

    initial begin
        #(40 * 20000);
        n_fail++;
        stop_test();
    end

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        {rst_n, t2_run, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        req = 11'h000;
        t2_period = 8'h05;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0;
        wstrb = 4'h1;
        n_fail = 0;
        tests_run = 0;
        m_f1 = 0;
        m_f2 = 0;
        m_en2 = 0;
        void'($urandom(32'h95e9b2c9));
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        rdr(IDX_FLAGS_1);
        chk(32'h0, rd);
        chk(32'(RESP_OKAY), 32'(resp));
        rdr(IDX_FLAGS_2);
        chk(32'h0, rd);
        rdr(IDX_ENABLES_2);
        chk(32'h0, rd);
        // each event sets its own bit with every enable off
        for (i = 0; i < 8; i++) begin
            if (i == 1) continue;
            pulse(i);
            m_f1 |= 1 << i;
            rdr(IDX_FLAGS_1);
            chk(32'(m_f1), rd);
        end
        t2_run <= 1'b1;
        repeat (12) @(posedge core_clk);
        t2_run <= 1'b0;
        m_f1 |= 2;
        rdr(IDX_FLAGS_1);
        chk(32'(m_f1), rd);
        // software clears only the writable flags
        wr(IDX_FLAGS_1, 8'h00);
        chk(32'(RESP_OKAY), 32'(resp));
        m_f1 &= 8'h30;
        rdr(IDX_FLAGS_1);
        chk(32'(m_f1), rd);
        pulse(9);
        pulse(10);
        m_f1 = 0;
        rdr(IDX_FLAGS_1);
        chk(32'(m_f1), rd);
        pulse(5);
        d = 8'($urandom);
        wr(IDX_FLAGS_1, d);
        m_f1 = 8'h20 | (d & 8'hcf);
        rdr(IDX_FLAGS_1);
        chk(32'(m_f1), rd);
        wr(IDX_FLAGS_1, 8'h00);
        m_f1 &= 8'h30;
        // capcomp2 flag, its enable and the interrupt line
        pulse(8);
        m_f2 = 1;
        rdr(IDX_FLAGS_2);
        chk(32'(m_f2), rd);
        // stale flag cleared before its enable goes on
        wr(IDX_FLAGS_2, 8'h00);
        m_f2 = 0;
        rdr(IDX_FLAGS_2);
        chk(32'(m_f2), rd);
        d = 8'($urandom);
        wr(IDX_ENABLES_2, d);
        m_en2 = d & 8'h01;
        rdr(IDX_ENABLES_2);
        chk(32'(m_en2), rd);
        wr(IDX_ENABLES_2, 8'h01);
        wr(IDX_CONTROL, 8'h03);
        repeat (3) @(posedge core_clk);
        chk(32'h0, {31'h0, irq});
        pulse(8);
        chk(32'h1, {31'h0, irq});
        wr(IDX_CONTROL, 8'h02);
        repeat (3) @(posedge core_clk);
        chk(32'h0, {31'h0, irq});
        wr(IDX_CONTROL, 8'h03);
        wr(IDX_FLAGS_2, 8'h00);
        repeat (3) @(posedge core_clk);
        chk(32'h0, {31'h0, irq});
        // unmapped places answer with an error
        rdr(8'h40);
        chk(32'(RESP_SLVERR), 32'(resp));
        chk(32'h0, rd);
        wr(8'h41, 8'hff);
        chk(32'(RESP_SLVERR), 32'(resp));
        // without the parallel port bit 7 stays clear
        pulse(7);
        m_f1 |= 8'h80;
        rdr(IDX_FLAGS_1);
        chk(32'(m_f1), rd);
        wr(IDX_CONTROL, 8'h01);
        m_f1 &= 8'h7f;
        rdr(IDX_FLAGS_1);
        chk(32'(m_f1), rd);
        pulse(7);
        wr(IDX_FLAGS_1, 8'h80);
        rdr(IDX_FLAGS_1);
        chk(32'(m_f1), rd);
        stop_test();
    end
endmodule : peripheral_irq_flags_tb
`default_nettype wire
